/* verilog/jtsp_pkg.sv */
// package for the sram test access port: instruction codes, id fields, chain sizes
// assumes a single system clock that oversamples the test clock pin
package jtsp_pkg;
    localparam int IR_W      = 3;
    localparam int ID_W      = 32;
    localparam int BSR_W     = 109;
    localparam int SYNC_W    = 2;
    localparam logic [IR_W-1:0] INS_EXTEST   = 3'h0;
    localparam logic [IR_W-1:0] INS_IDLOAD   = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPZ    = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;
    localparam logic [1:0]      IR_CAPT_PAT  = 2'h1;
    localparam int TRI_BIT = 108;
    // id field positions
    localparam int ID_REV_LSB = 29;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_VEN_LSB = 1;
    // arbitrary neutral identity values
    localparam logic [2:0]  ID_REV_DEF = 3'h5;
    localparam logic [16:0] ID_DEV_DEF = 17'h0abcd;
    localparam logic [10:0] ID_VEN_DEF = 11'h123;
    localparam logic        ID_PRESENT = 1'h1;
    typedef enum logic [15:0] {
        ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002, ST_SELDR  = 16'h0004, ST_CAPDR  = 16'h0008,
        ST_SHDR   = 16'h0010, ST_EX1DR  = 16'h0020, ST_PSDR   = 16'h0040, ST_EX2DR  = 16'h0080,
        ST_UPDR   = 16'h0100, ST_SELIR  = 16'h0200, ST_CAPIR  = 16'h0400, ST_SHIR   = 16'h0800,
        ST_EX1IR  = 16'h1000, ST_PSIR   = 16'h2000, ST_EX2IR  = 16'h4000, ST_UPIR   = 16'h8000
    } jtsp_state_t;
endpackage

/* verilog/jtsp_sync.sv */
// two flip-flop synchroniser for the test pins
// assumes inputs asynchronous to clock
module jtsp_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    // pins
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

/* verilog/jtsp_tap.sv */
// test access port of a synchronous sram: tap controller, instruction, bypass, id, boundary chain
// assumes clock much faster than the test clock; pins arrive asynchronous
module jtsp_tap
    import jtsp_pkg::*;
#(
    parameter logic [2:0]  ID_REV = jtsp_pkg::ID_REV_DEF,
    parameter logic [16:0] ID_DEV = jtsp_pkg::ID_DEV_DEF,
    parameter logic [10:0] ID_VEN = jtsp_pkg::ID_VEN_DEF
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          resetn,
    // test pins
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo_o,
    output logic                               tdo_oe,
    // pin ring
    input  wire logic [jtsp_pkg::BSR_W-1:0]    ring_in,
    output logic      [jtsp_pkg::BSR_W-1:0]    ring_drive,
    output logic                               ring_test_mode,
    output logic                               mem_out_off,
    output logic      [jtsp_pkg::IR_W-1:0]     active_ins
);
    import jtsp_pkg::*;

    logic [2:0]            pins_s;
    logic                  tck_s, tms_s, tdi_s, tck_d_r;
    logic                  rise, fall;
    jtsp_state_t           st_r, st_nxt;
    logic [IR_W-1:0]       ir_shift_r;
    logic                  bypass_r;
    logic [ID_W-1:0]       id_shift_r;
    logic [BSR_W-1:0]      bsr_r;
    logic                  ser_out;

    jtsp_sync #(.W(3)) u_sync (
        .clock    (clock),
        .resetn   (resetn),
        .async_in ({tck, tms, tdi}),
        .sync_out (pins_s)
    );
    assign tck_s = pins_s[2];
    assign tms_s = pins_s[1];
    assign tdi_s = pins_s[0];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end
    assign rise = tck_s & ~tck_d_r;
    assign fall = ~tck_s & tck_d_r;

    function automatic logic is_chain(input logic [IR_W-1:0] ins);
        is_chain = (ins == INS_EXTEST) || (ins == INS_SAMPZ) || (ins == INS_SAMPLE);
    endfunction

    // controller next state
    always_comb begin
        case (st_r)
            ST_RESET: st_nxt = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE:  st_nxt = tms_s ? ST_SELDR : ST_IDLE;
            ST_SELDR: st_nxt = tms_s ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: st_nxt = tms_s ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  st_nxt = tms_s ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: st_nxt = tms_s ? ST_UPDR  : ST_PSDR;
            ST_PSDR:  st_nxt = tms_s ? ST_EX2DR : ST_PSDR;
            ST_EX2DR: st_nxt = tms_s ? ST_UPDR  : ST_SHDR;
            ST_UPDR:  st_nxt = tms_s ? ST_SELDR : ST_IDLE;
            ST_SELIR: st_nxt = tms_s ? ST_RESET : ST_CAPIR;
            ST_CAPIR: st_nxt = tms_s ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  st_nxt = tms_s ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: st_nxt = tms_s ? ST_UPIR  : ST_PSIR;
            ST_PSIR:  st_nxt = tms_s ? ST_EX2IR : ST_PSIR;
            ST_EX2IR: st_nxt = tms_s ? ST_UPIR  : ST_SHIR;
            ST_UPIR:  st_nxt = tms_s ? ST_SELDR : ST_IDLE;
            default:  st_nxt = ST_RESET;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_RESET;
        end else if (rise) begin
            st_r <= st_nxt;
        end
    end

    // instruction shift and update
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ir_shift_r <= INS_IDLOAD;
        end else if (rise) begin
            if (st_r == ST_CAPIR) begin
                ir_shift_r <= {active_ins[IR_W-1], IR_CAPT_PAT};
            end else if (st_r == ST_SHIR) begin
                ir_shift_r <= {tdi_s, ir_shift_r[IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            active_ins <= INS_IDLOAD;
        end else if (rise) begin
            if (st_nxt == ST_RESET) begin
                active_ins <= INS_IDLOAD;
            end else if (st_r == ST_UPIR) begin
                active_ins <= ir_shift_r;
            end
        end
    end

    // bypass cell
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bypass_r <= 1'b0;
        end else if (rise) begin
            if (st_r == ST_CAPDR) begin
                bypass_r <= 1'b0;
            end else if (st_r == ST_SHDR) begin
                bypass_r <= tdi_s;
            end
        end
    end

    // id register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            id_shift_r <= '0;
        end else if (rise && active_ins == INS_IDLOAD) begin
            if (st_r == ST_CAPDR) begin
                id_shift_r <= {ID_REV, ID_DEV, ID_VEN, ID_PRESENT};
            end else if (st_r == ST_SHDR) begin
                id_shift_r <= {tdi_s, id_shift_r[ID_W-1:1]};
            end
        end
    end

    // boundary chain: msb at data in, lsb at data out
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bsr_r <= '0;
        end else if (rise && is_chain(active_ins)) begin
            if (st_r == ST_CAPDR) begin
                bsr_r <= ring_in;
            end else if (st_r == ST_SHDR) begin
                bsr_r <= {tdi_s, bsr_r[BSR_W-1:1]};
            end
        end
    end

    // preload latch; tri-state cell preset high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ring_drive          <= '0;
            ring_drive[TRI_BIT] <= 1'b1;
        end else if (rise) begin
            if (st_nxt == ST_RESET) begin
                ring_drive[TRI_BIT] <= 1'b1;
            end else if (st_r == ST_UPDR && is_chain(active_ins)) begin
                ring_drive <= bsr_r;
            end
        end
    end

    // effects on the memory side
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ring_test_mode <= 1'b0;
            mem_out_off    <= 1'b0;
        end else begin
            ring_test_mode <= (active_ins == INS_EXTEST);
            mem_out_off    <= (active_ins == INS_SAMPZ) ||
                              (active_ins == INS_EXTEST && !ring_drive[TRI_BIT]);
        end
    end

    // serial output select
    always_comb begin
        if (st_r == ST_SHIR) begin
            ser_out = ir_shift_r[0];
        end else if (active_ins == INS_IDLOAD) begin
            ser_out = id_shift_r[0];
        end else if (is_chain(active_ins)) begin
            ser_out = bsr_r[0];
        end else begin
            ser_out = bypass_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (fall) begin
            tdo_o  <= ser_out;
            tdo_oe <= (st_r == ST_SHIR) || (st_r == ST_SHDR);
        end
    end
endmodule

/* bench/jtsp_tap_chk.sv */
// checker for jtsp_tap: port timing of data out, instruction and modes
// assumes clock oversamples tck as jtsp_tap does
module jtsp_tap_chk
    import jtsp_pkg::*;
(
    // clock and reset
    input wire logic                        clock,
    input wire logic                        resetn,
    // test pins
    input wire logic                        tck,
    input wire logic                        tms,
    input wire logic                        tdo_o,
    input wire logic                        tdo_oe,
    // ring and instruction
    input wire logic [jtsp_pkg::BSR_W-1:0] ring_drive,
    input wire logic                        ring_test_mode,
    input wire logic                        mem_out_off,
    input wire logic [jtsp_pkg::IR_W-1:0]  active_ins
);
    import jtsp_pkg::*;
    logic       tck_d;
    logic [2:0] rise_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // consecutive tck rises with tms high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tck_d    <= 1'b0;
            rise_cnt <= 3'h0;
        end else begin
            tck_d <= tck;
            if (tck && !tck_d) begin
                rise_cnt <= !tms ? 3'h0 : (rise_cnt == 3'h5 ? 3'h5 : rise_cnt + 3'h1);
            end
        end
    end
    a_tdo_on_fall: assert property (!$stable(tdo_o) |-> !tck && !$past(tck, 2)) else $error("tdo moved");
    a_oe_rise_low: assert property ($rose(tdo_oe) |-> !tck) else $error("oe rose");
    a_oe_fall_low: assert property ($fell(tdo_oe) |-> !tck) else $error("oe fell");
    a_ins_on_rise: assert property (!$stable(active_ins) |-> tck) else $error("ins moved");
    a_ring_mode: assert property ($stable(active_ins) |-> ring_test_mode == (active_ins == INS_EXTEST))
        else $error("ring mode");
    a_mem_off_sel: assert property ($stable(active_ins) && $stable(ring_drive[TRI_BIT]) |-> mem_out_off ==
        (active_ins == INS_SAMPZ || (active_ins == INS_EXTEST && !ring_drive[TRI_BIT]))) else $error("mem off");
    a_reset_idload: assert property ($rose(resetn) |-> active_ins == INS_IDLOAD) else $error("reset ins");
    a_tms_reset: assert property (rise_cnt == 3'h5 |-> ##[0:8] active_ins == INS_IDLOAD) else $error("tms rst");
endmodule
bind jtsp_tap jtsp_tap_chk i_jtsp_tap_chk (.clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .ring_drive(ring_drive), .ring_test_mode(ring_test_mode), .mem_out_off(mem_out_off),
    .active_ins(active_ins));

/* bench/jtsp_ctl_model.sv */
// external test controller model: drives test pins, reads data out
// assumes the bench calls its tasks; tck stands low between frames
module jtsp_ctl_model (
    // test pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo_o,
    input  wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 125 ns cycle, returns data out seen before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdo_oe ? tdo_o : 1'bz;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask
    // five rises with mode high
    task automatic tap_reset;
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
    endtask
endmodule

/* bench/jtsp_tap_bench.sv */
// bench for jtsp_tap: controller model walks the five defined instruction codes, skipping 3, 5 and 6
// assumes jtsp_tap_chk is bound from its own file
module jtsp_tap_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import jtsp_pkg::*;
    localparam logic [31:0] IDV = {ID_REV_DEF, ID_DEV_DEF, ID_VEN_DEF, 1'b1};
    logic             clock = 1'b0;
    logic             resetn = 1'b0;
    logic             tck, tms, tdi, tdo_o, tdo_oe, ring_test_mode, mem_out_off, q, pre108;
    logic [BSR_W-1:0] ring_in = '0;
    logic [BSR_W-1:0] ring_drive;
    logic [IR_W-1:0]  active_ins;
    logic [127:0]     din, dout, rnd;
    logic             exp_q[$];
    int               bad_count = 0, n_compared = 0, seed = 31560, n;
    jtsp_tap i_jtsp_tap (.clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
        .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_drive(ring_drive), .ring_test_mode(ring_test_mode),
        .mem_out_off(mem_out_off), .active_ins(active_ins));
    jtsp_ctl_model i_jtsp_ctl_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
    initial forever #4 clock = ~clock;
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // idle, select, capture, shift n bits lsb first, update, idle
    task automatic scan(input bit ir, input int nb);
        i_jtsp_ctl_model.step(1'b1, 1'b0, q);
        if (ir) i_jtsp_ctl_model.step(1'b1, 1'b0, q);
        repeat (2) i_jtsp_ctl_model.step(1'b0, 1'b0, q);
        for (int i = 0; i < nb; i++) i_jtsp_ctl_model.step(i == nb - 1, din[i], dout[i]);
        i_jtsp_ctl_model.step(1'b1, 1'b0, q);
        repeat (2) i_jtsp_ctl_model.step(1'b0, 1'b0, q);
        check("tdo idle", q, 1'bz);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check("ins reset", active_ins, INS_IDLOAD);
        pre108 = 1'b1;
        #0.3;
        i_jtsp_ctl_model.tap_reset();
        i_jtsp_ctl_model.step(1'b0, 1'b0, q);
        for (int c = 0; c < 8; c++) begin
            if (c inside {3, 5, 6}) continue;
            din = 128'(c);
            scan(1'b1, IR_W);
            check("ir capture", dout[1:0], IR_CAPT_PAT);
            if (!(c inside {3, 5, 6})) check("ins", active_ins, c[2:0]);
            check("ring mode", ring_test_mode, c == 0);
            check("mem off", mem_out_off, c == 2);
            rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
            din = {$random(seed), $random(seed), $random(seed), $random(seed)};
            @(posedge clock);
            ring_in <= rnd[BSR_W-1:0];
            #0.3;
            n = (c % 2 == 0 && c != 6) ? BSR_W : (c == 1 ? ID_W : 8);
            exp_q.delete();
            for (int i = 0; i < n; i++) begin
                exp_q.push_back(n == BSR_W ? rnd[i] : (n == ID_W ? IDV[i] : (i == 0 ? 1'b0 : din[i-1])));
            end
            scan(1'b0, n);
            foreach (exp_q[i]) check("dr bit", dout[i], exp_q[i]);
            if (n == BSR_W) begin
                check("preload", ring_drive, din[BSR_W-1:0]);
                pre108 = din[TRI_BIT];
            end
            check("mem off dr", mem_out_off, c == 2 || (c == 0 && !pre108));
        end
        // tap reset from deep inside shift-dr takes all five rises
        i_jtsp_ctl_model.step(1'b1, 1'b0, q);
        repeat (2) i_jtsp_ctl_model.step(1'b0, 1'b0, q);
        i_jtsp_ctl_model.tap_reset();
        check("ins tms reset", active_ins, INS_IDLOAD);
        check("tri preset", ring_drive[TRI_BIT], 1'b1);
        end_sim();
    end
    initial begin
        #500000;
        bad_count++;
        end_sim();
    end
endmodule
